// ==== src/rvc_ring_validation.sv ====
// rvc_ring_validation: ring frequency qualification with delayed valid-ring indication
// assumes ring_event is a one-cycle pulse synchronous to aclk from the line-side detector
// Notes on behaviour
// - delay code is {ctrl2 bit7, ctrl1 bits7:6}
// - wait selected delay before signalling valid ring
// - max-count field bits5:0 bounds accepted frequency
// - event loads countdown with preload, then decrements
// - next event: timer above max-count invalidates ring
// - events come twice per ring period
//
// The implementer's own choice: the AXI4-Lite register port.
module rvc_ring_validation
    import rvc_pkg::*;
#(
    parameter int unsigned STEP_CYC = DLY_STEP_CYC,
    parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // ring detector
    input wire logic ring_event,
    // status
    output logic ring_valid,
    output logic irq,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // refuse timing values that the counters cannot hold
    if (STEP_CYC < 1 || STEP_CYC > 32'h0FFF_FFFF || TICK_CYCLES < 1 || TICK_CYCLES > 32'h00FF_FFFF)
    begin : g_bad_timing
        $error("rvc_ring_validation: bad timing parameter");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_DELAY = 3'b100
    } rvc_state_t;

    typedef struct packed {
        rvc_state_t st;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [1:0] irq_st;
        logic [1:0] mask;
        logic [5:0] timer;
        logic [23:0] tick;
        logic [2:0] dly_code;
        logic [2:0] dly_units;
        logic [27:0] dly_cnt;
        logic valid;
        logic irq;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rvc_regs_t;

    rvc_regs_t r_q;
    rvc_regs_t r_d;

    // read decode used by the read channel
    function automatic logic [31:0] read_word(input rvc_regs_t r, input logic [7:0] a, output logic ok);
        logic [31:0] v;
        v = 32'h0000_0000;
        ok = 1'b1;
        unique case (a)
            ADDR_CTRL1: v = {24'h00_0000, r.ctrl1};
            ADDR_CTRL2: v = {24'h00_0000, r.ctrl2};
            ADDR_STAT: v = {24'h00_0000, r.valid, 1'b0, r.timer};
            ADDR_IRQ: v = {30'h0000_0000, r.irq_st};
            ADDR_MASK: v = {30'h0000_0000, r.mask};
            default: ok = 1'b0;
        endcase
        return v;
    endfunction

    // byte-lane merge for 8-bit registers
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        return s[0] ? d[7:0] : old;
    endfunction

    always_comb
    begin
        logic ok;
        logic [31:0] rd;
        logic [1:0] ev;
        logic [1:0] clr;
        logic wr_ok;
        ok = 1'b0;
        rd = 32'h0000_0000;
        ev = 2'b00;
        clr = 2'b00;
        wr_ok = 1'b0;
        r_d = r_q;

        // write channel: address and data in either order
        r_d.awready = 1'b0;
        r_d.wready = 1'b0;
        if (!r_q.aw_got && !r_q.awready && s_axi_awvalid && !r_q.bvalid)
        begin
            r_d.awready = 1'b1;
        end
        if (r_q.awready && s_axi_awvalid)
        begin
            r_d.aw_got = 1'b1;
            r_d.aw_addr = s_axi_awaddr;
        end
        if (!r_q.w_got && !r_q.wready && s_axi_wvalid && !r_q.bvalid)
        begin
            r_d.wready = 1'b1;
        end
        if (r_q.wready && s_axi_wvalid)
        begin
            r_d.w_got = 1'b1;
            r_d.w_data = s_axi_wdata;
            r_d.w_strb = s_axi_wstrb;
        end
        if (r_q.aw_got && r_q.w_got && !r_q.bvalid)
        begin
            wr_ok = 1'b1;
            r_d.aw_got = 1'b0;
            r_d.w_got = 1'b0;
            r_d.bvalid = 1'b1;
            r_d.bresp = RESP_OKAY;
            unique case (r_q.aw_addr)
                ADDR_CTRL1: r_d.ctrl1 = lane0(r_q.ctrl1, r_q.w_data, r_q.w_strb);
                ADDR_CTRL2: r_d.ctrl2 = lane0(r_q.ctrl2, r_q.w_data, r_q.w_strb);
                ADDR_STAT: r_d.bresp = RESP_OKAY;
                ADDR_IRQ: clr = r_q.w_strb[0] ? r_q.w_data[1:0] : 2'b00;
                ADDR_MASK: r_d.mask = r_q.w_strb[0] ? r_q.w_data[1:0] : r_q.mask;
                default: r_d.bresp = RESP_SLVERR;
            endcase
        end
        if (r_q.bvalid && s_axi_bready)
        begin
            r_d.bvalid = 1'b0;
        end

        // read channel
        r_d.arready = 1'b0;
        if (!r_q.arready && !r_q.rvalid && s_axi_arvalid)
        begin
            r_d.arready = 1'b1;
        end
        if (r_q.arready && s_axi_arvalid)
        begin
            rd = read_word(r_q, s_axi_araddr, ok);
            r_d.rvalid = 1'b1;
            r_d.rdata = rd;
            r_d.rresp = ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (r_q.rvalid && s_axi_rready)
        begin
            r_d.rvalid = 1'b0;
        end

        // regular decrement tick
        if (r_q.tick >= 24'(TICK_CYCLES - 1))
        begin
            r_d.tick = 24'h00_0000;
        end
        else
        begin
            r_d.tick = r_q.tick + 24'h00_0001;
        end

        // countdown holds at zero between events
        if (r_q.tick >= 24'(TICK_CYCLES - 1) && r_q.timer != 6'h00)
        begin
            r_d.timer = r_q.timer - 6'h01;
        end

        // ring qualification: events arrive twice per ring period
        unique case (r_q.st)
            ST_IDLE:
            begin
                r_d.valid = 1'b0;
                if (ring_event)
                begin
                    r_d.timer = r_q.ctrl2[PRE_MSB:0];
                    r_d.tick = 24'h00_0000;
                    r_d.st = ST_ARMED;
                end
            end
            ST_ARMED:
            begin
                if (ring_event)
                begin
                    r_d.timer = r_q.ctrl2[PRE_MSB:0];
                    r_d.tick = 24'h00_0000;
                    if (r_q.timer > r_q.ctrl1[MAX_MSB:0])
                    begin
                        ev[IRQ_REJECT] = 1'b1;
                        r_d.valid = 1'b0;
                    end
                    else if (!r_q.valid)
                    begin
                        r_d.dly_code = {r_q.ctrl2[DLY_HI_BIT], r_q.ctrl1[DLY_LO_MSB:DLY_LO_LSB]};
                        r_d.dly_units = {r_q.ctrl2[DLY_HI_BIT], r_q.ctrl1[DLY_LO_MSB:DLY_LO_LSB]};
                        r_d.dly_cnt = 28'h000_0000;
                        if ({r_q.ctrl2[DLY_HI_BIT], r_q.ctrl1[DLY_LO_MSB:DLY_LO_LSB]} == 3'h0)
                        begin
                            r_d.valid = 1'b1;
                            ev[IRQ_VALID] = 1'b1;
                        end
                        else
                        begin
                            r_d.st = ST_DELAY;
                        end
                    end
                end
            end
            ST_DELAY:
            begin
                if (ring_event)
                begin
                    r_d.timer = r_q.ctrl2[PRE_MSB:0];
                    r_d.tick = 24'h00_0000;
                end
                if (ring_event && r_q.timer > r_q.ctrl1[MAX_MSB:0])
                begin
                    ev[IRQ_REJECT] = 1'b1;
                    r_d.st = ST_ARMED;
                end
                else if (r_q.dly_cnt >= 28'(STEP_CYC - 1))
                begin
                    r_d.dly_cnt = 28'h000_0000;
                    r_d.dly_units = r_q.dly_units - 3'h1;
                    if (r_q.dly_units == 3'h1)
                    begin
                        r_d.valid = 1'b1;
                        ev[IRQ_VALID] = 1'b1;
                        r_d.st = ST_ARMED;
                    end
                end
                else
                begin
                    r_d.dly_cnt = r_q.dly_cnt + 28'h000_0001;
                end
            end
        endcase

        // sticky status: set wins over write-one-to-clear
        r_d.irq_st = (r_q.irq_st & ~clr) | ev;
        r_d.irq = |(r_d.irq_st & r_d.mask);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.ctrl1 <= CTRL1_RST;
            r_q.ctrl2 <= CTRL2_RST;
            r_q.mask <= MASK_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign ring_valid = r_q.valid;
    assign irq = r_q.irq;
    assign s_axi_awready = r_q.awready;
    assign s_axi_wready = r_q.wready;
    assign s_axi_bvalid = r_q.bvalid;
    assign s_axi_bresp = r_q.bresp;
    assign s_axi_arready = r_q.arready;
    assign s_axi_rvalid = r_q.rvalid;
    assign s_axi_rdata = r_q.rdata;
    assign s_axi_rresp = r_q.rresp;
endmodule

// ==== src/rvc_pkg.sv ====
// rvc_pkg: constants for the ring validation control block
// assumes a 50 MHz device clock and a 32-bit axi4-lite register bus
package rvc_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CTRL1 = 8'h16;
    localparam logic [7:0] IDX_CTRL2 = 8'h17;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL1 = {IDX_CTRL1[5:0], 2'b00};
    localparam logic [7:0] ADDR_CTRL2 = {IDX_CTRL2[5:0], 2'b00};
    localparam logic [7:0] ADDR_STAT = 8'h1C;
    localparam logic [7:0] ADDR_IRQ = 8'h20;
    localparam logic [7:0] ADDR_MASK = 8'h24;
    // field positions
    localparam int DLY_LO_MSB = 7;
    localparam int DLY_LO_LSB = 6;
    localparam int MAX_MSB = 5;
    localparam int DLY_HI_BIT = 7;
    localparam int PRE_MSB = 5;
    // reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h19;
    localparam logic [1:0] MASK_RST = 2'h0;
    // delay step per code unit
    localparam int unsigned DLY_STEP_MS = 256;
    localparam int unsigned DLY_STEP_CYC = DLY_STEP_MS * (CLK_HZ / 1000);
    // regular decrement tick of the qualification timer
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = TICK_US * (CLK_HZ / 1000000);
    // interrupt bit positions
    localparam int IRQ_VALID = 0;
    localparam int IRQ_REJECT = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== dv/rvc_sva.sv ====
// rvc_sva: port checks for the ring validation block
// bound to every rvc_ring_validation; one clock, aclk
module rvc_sva
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // ring side
    input wire logic ring_event,
    input wire logic ring_valid,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ev_q;
    // events seen since reset, saturating at two
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ev_q <= 2'h0;
        else if (ring_event && ev_q != 2'h2)
            ev_q <= ev_q + 2'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_valid_hold: assert property (ring_valid && !ring_event |=> ring_valid) else $error("ring valid fell");
    a_valid_armed: assert property ($rose(ring_valid) |-> ev_q == 2'h2) else $error("valid too soon");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_ar_wait: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |-> ##[1:2] s_axi_arready)
        else $error("arready late");
endmodule

bind rvc_ring_validation rvc_sva i_sva (.*);

// ==== dv/rvc_ring_src.sv ====
// rvc_ring_src: line-side ring detector model
// assumes the bench calls fire from its main process
module rvc_ring_src
(
    // clock
    input wire logic aclk,
    // event pulse to the block
    output logic ring_event
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ring_event = 1'b0;
    // one event per half ring period; a short gap is a ring that is too fast
    task automatic fire(input int gap);
        repeat (gap) @(posedge aclk);
        ring_event <= 1'b1;
        @(posedge aclk);
        ring_event <= 1'b0;
    endtask
endmodule

// ==== dv/ring_validation_ctrl1_tb.sv ====
// ring_validation_ctrl1_tb: self-checking bench for rvc_ring_validation
// assumes rvc_pkg, rvc_ring_src and rvc_sva compiled first
module ring_validation_ctrl1_tb import rvc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned STEP = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d, e, lfsr = 32'hBB973BBD;
    logic [1:0] bresp, rresp, r;
    logic awr, wrd, bv, arr, rv, ev, valid, irq;
    logic [3:0] stb = 4'hF;
    int miscompares = 0, checks = 0, n;
    int codes[4] = '{1, 2, 3, 7};
    always #10 aclk = ~aclk;
    rvc_ring_src i_src (.aclk(aclk), .ring_event(ev));
    rvc_ring_validation #(.STEP_CYC(STEP), .TICK_CYCLES(2)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .ring_event(ev), .ring_valid(valid), .irq(irq),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(stb),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // expected cycles from validation to indication
    function automatic int dly(input int c);
        return c * STEP;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic hang(input int k);
        if (k >= 200)
        begin
            chk("wait", 32'h0, 32'h1);
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end
        while (!bv && n < 200);
        r = bresp;
        bre <= 1'b0;
        hang(n);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 1'b0;
        end
        while (!rv && n < 200);
        d = rdat;
        r = rresp;
        rre <= 1'b0;
        hang(n);
    endtask
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CTRL1);
        chk("ctrl1 rst", d, 32'h0);
        rd(ADDR_CTRL2);
        chk("ctrl2 rst", d, 32'h19);
        rd(8'h28);
        chk("unmapped", {30'h0, r}, 32'h2);
        repeat (4)
        begin
            e = rnd();
            wr(ADDR_CTRL1, e[7:0]);
            chk("bresp", {30'h0, r}, 32'h0);
            rd(ADDR_CTRL1);
            chk("ctrl1", d, {24'h0, e[7:0]});
        end
        // a write without lane 0 leaves the register alone
        stb <= 4'hE;
        wr(ADDR_CTRL1, 8'hFF);
        stb <= 4'hF;
        rd(ADDR_CTRL1);
        chk("strobe", d, {24'h0, e[7:0]});
        wr(8'h28, 8'h55);
        chk("bad write", {30'h0, r}, 32'h2);
        $display("test registers done");
        wr(ADDR_CTRL1, 8'h0A);
        i_src.fire(2);
        i_src.fire(10);
        rd(ADDR_IRQ);
        chk("reject", d, 32'h2);
        chk("masked", {31'h0, irq}, 32'h0);
        wr(ADDR_MASK, 8'h03);
        @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_IRQ, 8'h02);
        @(posedge aclk);
        chk("irq clr", {31'h0, irq}, 32'h0);
        chk("no valid", {31'h0, valid}, 32'h0);
        i_src.fire(60);
        chk("valid early", {31'h0, valid}, 32'h0);
        @(posedge aclk);
        chk("valid", {31'h0, valid}, 32'h1);
        rd(ADDR_STAT);
        chk("stat", {31'h0, d[7]}, 32'h1);
        // a fast event after validation invalidates the ring
        i_src.fire(2);
        @(posedge aclk);
        chk("invalidated", {31'h0, valid}, 32'h0);
        $display("test qualify done");
        foreach (codes[i])
        begin
            aresetn <= 1'b0;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            wr(ADDR_CTRL2, {codes[i][2], 7'h19});
            wr(ADDR_CTRL1, {codes[i][1:0], 6'h0A});
            i_src.fire(2);
            i_src.fire(60);
            n = 0;
            while (!valid && n < 200)
            begin
                @(posedge aclk);
                n++;
            end
            hang(n);
            // valid is seen one edge after the edge that launches it
            chk("delay", n, dly(codes[i]) + 1);
        end
        // a fast event during the delay aborts it
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wr(ADDR_CTRL1, 8'h4A);
        i_src.fire(2);
        i_src.fire(60);
        i_src.fire(3);
        repeat (20) @(posedge aclk);
        chk("delay abort", {31'h0, valid}, 32'h0);
        rd(ADDR_IRQ);
        chk("abort irq", d, 32'h2);
        $display("test delay done");
        give_verdict();
    end
endmodule
